// ===== hbbs_sequencer.sv
// Notes on behaviour
// - at start threshold hold lower gate on, upper off, before oscillating.
// - at run threshold start oscillator and drop bus-pin supply current.
// - dead time between gates (lower turns on at once when preheat drops to boot or open load); neither gate on half a period or more.
// - frequency always between floor and 2.5 times floor.
// - preheat begins at ceiling frequency, then lowers at once.
// - in preheat sample sense comparator as lower gate turns off.
// - preheat lowers frequency above warmup threshold, raises it below.
// - once warmup threshold reached, hold frequency for rest of warmup.
// - warmup time is 16 completed timing capacitor cycles.
// - timing pin grounded keeps device in preheat forever.
// - floor reached in preheat means open load: latch lower on.
// - after warmup, strike phase sweeps frequency down to floor.
// - strike ends at floor or after 15 timing cycles.
// - from strike, sense voltage serves capacitive-mode protection.
// - after preheat bus pin senses bus; high current raises frequency.
// - strike and run sample at lower turn-on; below 20mV raise frequency.
// - run frequency is max of floor, feed-forward, capacitive value.
// - stop below stop threshold, resume only above run threshold.
// - restart at ceiling, shift to floor over 15 cycles, then run.
`timescale 1ns/10ps
`include "hbbs_cfg.svh"
module hbbs_sequencer
(
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             supply_start_pin,
    input  wire logic             supply_run_pin,
    input  wire logic             supply_stop_pin,
    input  wire logic             sense_above_warmup_pin,
    input  wire logic             sense_below_hard_pin,
    input  wire logic             bus_over_level_pin,
    input  wire logic             timing_cycle_pin,
    input  wire logic             timing_grounded_pin,
    output logic                  upper_gate,
    output logic                  lower_gate,
    output logic                  bus_sense_supply_en,
    output logic                  bus_sense_measure_en,
    output logic                  open_load,
    output hbbs_pkg::hbbs_phase_type phase
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    hbbs_pkg::hbbs_supply_type sup;
    logic                      warm_hi;
    logic                      hard_lo;
    logic                      bus_hi;
    logic                      tcyc_s;
    logic                      tgnd;
    logic                      tcyc_rise;

    hbbs_sync u_s0 (.mclk(mclk), .rst_n(rst_n), .d(supply_start_pin),
                    .q(sup.start_ok));
    hbbs_sync u_s1 (.mclk(mclk), .rst_n(rst_n), .d(supply_run_pin),
                    .q(sup.run_ok));
    hbbs_sync u_s2 (.mclk(mclk), .rst_n(rst_n), .d(supply_stop_pin),
                    .q(sup.stop_low));
    hbbs_sync u_s3 (.mclk(mclk), .rst_n(rst_n), .d(sense_above_warmup_pin),
                    .q(warm_hi));
    hbbs_sync u_s4 (.mclk(mclk), .rst_n(rst_n), .d(sense_below_hard_pin),
                    .q(hard_lo));
    hbbs_sync u_s5 (.mclk(mclk), .rst_n(rst_n), .d(bus_over_level_pin),
                    .q(bus_hi));
    hbbs_sync u_s6 (.mclk(mclk), .rst_n(rst_n), .d(timing_cycle_pin),
                    .q(tcyc_s));
    hbbs_sync u_s7 (.mclk(mclk), .rst_n(rst_n), .d(timing_grounded_pin),
                    .q(tgnd));

    // each completed timing capacitor cycle counts once
    hbbs_edge u_e0 (.mclk(mclk), .rst_n(rst_n), .d(tcyc_s),
                    .rise(tcyc_rise));

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    hbbs_pkg::hbbs_phase_type phase_r;
    hbbs_pkg::hbbs_phase_type phase_nxt;
    logic [`HBBS_FREQ_W-1:0]  half_r;
    logic [`HBBS_FREQ_W-1:0]  half_cnt_r;
    logic [7:0]               dead_cnt_r;
    logic                     side_r;
    logic [4:0]               tcnt_r;
    logic                     warm_lock_r;
    logic                     warm_cross;
    logic                     restart_r;
    logic [7:0]               upd_cnt_r;
    logic                     upd;
    logic                     warm_smp_r;
    logic                     hard_smp_r;
    logic                     lower_off_ev;
    logic                     lower_on_ev;
    logic                     osc_on;
    logic                     at_floor;
    logic                     at_ceil;
    hbbs_pkg::hbbs_gate_type  gate_nxt;

    assign osc_on   = (phase_r == hbbs_pkg::HBBS_WARM)
                   || (phase_r == hbbs_pkg::HBBS_STRIKE)
                   || (phase_r == hbbs_pkg::HBBS_RUN)
                   || (phase_r == hbbs_pkg::HBBS_RESTART);
    assign at_floor = (half_r >= `HBBS_FLOOR_HALF);
    assign at_ceil  = (half_r <= `HBBS_CEIL_HALF);
    assign upd      = (upd_cnt_r == 8'h00);
    // a below sample once off the ceiling means warmup current reached
    assign warm_cross = upd && (phase_r == hbbs_pkg::HBBS_WARM)
                     && !warm_lock_r && !warm_smp_r && !at_ceil;

    // ------------------------------------------------------------
    // phase sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        phase_nxt = phase_r;
        unique case (phase_r)
            hbbs_pkg::HBBS_OFF:
                if (sup.start_ok && !restart_r)
                    phase_nxt = hbbs_pkg::HBBS_BOOT;
            hbbs_pkg::HBBS_BOOT:
                if (sup.run_ok)
                    phase_nxt = hbbs_pkg::HBBS_WARM;
            hbbs_pkg::HBBS_WARM:
                if (at_floor && upd)
                    phase_nxt = hbbs_pkg::HBBS_OPEN;
                else if (!tgnd && tcyc_rise
                         && tcnt_r == `HBBS_WARMUP_CNT - 5'd1)
                    phase_nxt = hbbs_pkg::HBBS_STRIKE;
            hbbs_pkg::HBBS_STRIKE:
                if (at_floor
                    || (tcyc_rise && tcnt_r == `HBBS_STRIKE_CNT - 5'd1))
                    phase_nxt = hbbs_pkg::HBBS_RUN;
            hbbs_pkg::HBBS_RUN:
                ;
            hbbs_pkg::HBBS_OPEN:
                ;
            hbbs_pkg::HBBS_RESTART:
                if (tcyc_rise && tcnt_r == `HBBS_STRIKE_CNT - 5'd1)
                    phase_nxt = hbbs_pkg::HBBS_RUN;
            default:
                phase_nxt = hbbs_pkg::HBBS_OFF;
        endcase
        // undervoltage overrides; open load clears only below start
        if (!sup.start_ok)
            phase_nxt = hbbs_pkg::HBBS_OFF;
        else if (sup.stop_low && osc_on)
            phase_nxt = (phase_r == hbbs_pkg::HBBS_WARM)
                      ? hbbs_pkg::HBBS_BOOT
                      : hbbs_pkg::HBBS_OFF;
        else if (phase_r == hbbs_pkg::HBBS_OFF && restart_r && sup.run_ok
                 && !sup.stop_low)
            phase_nxt = hbbs_pkg::HBBS_RESTART;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            phase_r <= hbbs_pkg::HBBS_OFF;
        else
            phase_r <= phase_nxt;
    end

    // a stop out of strike, run or restart waits in off for the run level, then
    // restarts at the ceiling instead of repeating the warmup
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            restart_r <= 1'b0;
        else if (!sup.start_ok)
            restart_r <= 1'b0;
        else if (sup.stop_low && osc_on && phase_r != hbbs_pkg::HBBS_WARM)
            restart_r <= 1'b1;
        else if (phase_r == hbbs_pkg::HBBS_RESTART)
            restart_r <= 1'b0;
    end

    // ------------------------------------------------------------
    // timing capacitor cycle counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            tcnt_r <= 5'd0;
        else if (phase_nxt != phase_r)
            tcnt_r <= 5'd0;
        else if (tcyc_rise && !tgnd)
            tcnt_r <= tcnt_r + 5'd1;
    end

    // ------------------------------------------------------------
    // control update tick
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            upd_cnt_r <= `HBBS_UPD_CYC;
        else if (upd)
            upd_cnt_r <= `HBBS_UPD_CYC;
        else
            upd_cnt_r <= upd_cnt_r - 8'd1;
    end

    // ------------------------------------------------------------
    // comparator sampling at gate edges
    // ------------------------------------------------------------
    assign lower_off_ev = osc_on && !side_r && (half_cnt_r == 12'h000)
                       && (dead_cnt_r == 8'h00);
    // half_r may move inside the dead window; watch the gate instead
    assign lower_on_ev  = osc_on && gate_nxt.lower_gate && !lower_gate;

    // no sample yet reads as above, so warmup leaves the ceiling
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            warm_smp_r <= 1'b1;
        else if (phase_r != hbbs_pkg::HBBS_WARM)
            warm_smp_r <= 1'b1;
        else if (lower_off_ev)
            warm_smp_r <= warm_hi;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            hard_smp_r <= 1'b0;
        else if (phase_r == hbbs_pkg::HBBS_WARM)
            hard_smp_r <= 1'b0;
        else if (lower_on_ev)
            hard_smp_r <= hard_lo;
    end

    // ------------------------------------------------------------
    // warmup threshold lock
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            warm_lock_r <= 1'b0;
        else if (phase_r != hbbs_pkg::HBBS_WARM)
            warm_lock_r <= 1'b0;
        else if (warm_cross)
            warm_lock_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // frequency control word (half period; larger is lower frequency)
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            half_r <= `HBBS_CEIL_HALF;
        else if (!osc_on)
            half_r <= `HBBS_CEIL_HALF;
        else if (upd)
        begin
            // any raise request wins; floor is the run default
            if (hard_smp_r || (bus_hi && phase_r != hbbs_pkg::HBBS_WARM)
                || warm_cross)
            begin
                if (!at_ceil)
                    half_r <= half_r - `HBBS_STEP;
            end
            else if (phase_r == hbbs_pkg::HBBS_WARM && warm_lock_r)
                half_r <= half_r;
            else if (!at_floor)
                half_r <= half_r + `HBBS_STEP;
        end
    end

    // ------------------------------------------------------------
    // half-bridge timing with dead time
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            half_cnt_r <= 12'h000;
            dead_cnt_r <= 8'h00;
            side_r     <= 1'b0;
        end
        else if (!osc_on)
        begin
            half_cnt_r <= half_r;
            dead_cnt_r <= 8'h00;
            side_r     <= 1'b0;
        end
        else if (dead_cnt_r != 8'h00)
            dead_cnt_r <= dead_cnt_r - 8'd1;
        else if (half_cnt_r == 12'h000)
        begin
            half_cnt_r <= half_r;
            side_r     <= ~side_r;
            dead_cnt_r <= 8'(`HBBS_DEAD_CYC);
        end
        else
            half_cnt_r <= half_cnt_r - 12'd1;
    end

    always_comb
    begin
        gate_nxt = '0;
        unique case (phase_r)
            hbbs_pkg::HBBS_BOOT,
            hbbs_pkg::HBBS_OPEN:
                gate_nxt.lower_gate = 1'b1;
            hbbs_pkg::HBBS_WARM,
            hbbs_pkg::HBBS_STRIKE,
            hbbs_pkg::HBBS_RUN,
            hbbs_pkg::HBBS_RESTART:
            begin
                // gates only on outside the dead window
                gate_nxt.upper_gate = side_r && dead_cnt_r == 8'h00;
                gate_nxt.lower_gate = !side_r && dead_cnt_r == 8'h00;
            end
            hbbs_pkg::HBBS_OFF:
                gate_nxt = '0;
            default:
                gate_nxt = '0;
        endcase
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            upper_gate           <= 1'b0;
            lower_gate           <= 1'b0;
            bus_sense_supply_en  <= 1'b1;
            bus_sense_measure_en <= 1'b0;
            open_load            <= 1'b0;
            phase                <= hbbs_pkg::HBBS_OFF;
        end
        else
        begin
            upper_gate           <= gate_nxt.upper_gate;
            lower_gate           <= gate_nxt.lower_gate;
            bus_sense_supply_en  <= (phase_r == hbbs_pkg::HBBS_OFF)
                                 || (phase_r == hbbs_pkg::HBBS_BOOT);
            bus_sense_measure_en <= (phase_r == hbbs_pkg::HBBS_STRIKE)
                                 || (phase_r == hbbs_pkg::HBBS_RUN)
                                 || (phase_r == hbbs_pkg::HBBS_RESTART);
            open_load            <= (phase_r == hbbs_pkg::HBBS_OPEN);
            phase                <= phase_r;
        end
    end
endmodule : hbbs_sequencer

// ===== hbbs_cfg.svh
`ifndef HBBS_CFG_SVH
`define HBBS_CFG_SVH
// frequency control word: period in mclk cycles per half period
`define HBBS_FREQ_W        12
// floor frequency half period (cycles) and ceiling = floor / 2.5
`define HBBS_FLOOR_HALF    12'd1000
`define HBBS_CEIL_HALF     12'd400
`define HBBS_DEAD_NS       1400
`define HBBS_CLK_NS        10
`define HBBS_DEAD_CYC      ((`HBBS_DEAD_NS + `HBBS_CLK_NS - 1) / `HBBS_CLK_NS)
`define HBBS_STEP          12'd1
`define HBBS_WARMUP_CNT    5'd16
`define HBBS_STRIKE_CNT    5'd15
// control update once every this many cycles plus one
`define HBBS_UPD_CYC       8'd64
`endif

// ===== hbbs_pkg.sv
package hbbs_pkg;
    typedef enum logic [2:0] {
        HBBS_OFF     = 3'b000,
        HBBS_BOOT    = 3'b001,
        HBBS_WARM    = 3'b010,
        HBBS_STRIKE  = 3'b011,
        HBBS_RUN     = 3'b100,
        HBBS_OPEN    = 3'b101,
        HBBS_RESTART = 3'b110
    } hbbs_phase_type;

    typedef struct packed {
        logic start_ok;
        logic run_ok;
        logic stop_low;
    } hbbs_supply_type;

    typedef struct packed {
        logic upper_gate;
        logic lower_gate;
    } hbbs_gate_type;
endpackage : hbbs_pkg

// ===== hbbs_sync.sv
`timescale 1ns/10ps
module hbbs_sync
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    logic s1_r;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= 1'b0;
            q    <= 1'b0;
        end
        else
        begin
            s1_r <= d;
            q    <= s1_r;
        end
    end
endmodule : hbbs_sync

// ===== hbbs_edge.sv
`timescale 1ns/10ps
module hbbs_edge
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      rise
);
    logic d_r;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            d_r <= 1'b0;
        else
            d_r <= d;
    end

    assign rise = d & ~d_r;
endmodule : hbbs_edge

// ===== hbbs_assertions.sv
`timescale 1ns/10ps
module hbbs_assertions
(
    input wire logic                     mclk,
    input wire logic                     rst_n,
    input wire logic                     supply_start_pin,
    input wire logic                     upper_gate,
    input wire logic                     lower_gate,
    input wire logic                     bus_sense_supply_en,
    input wire logic                     bus_sense_measure_en,
    input wire logic                     open_load,
    input wire hbbs_pkg::hbbs_phase_type phase
);
    // ----------
    // helpers
    // ----------
    logic [10:0] on_r;
    logic [7:0]  gap_r;
    logic        osc;

    assign osc = phase inside {hbbs_pkg::HBBS_WARM, hbbs_pkg::HBBS_STRIKE,
                               hbbs_pkg::HBBS_RUN, hbbs_pkg::HBBS_RESTART};

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            on_r <= 11'h000;
        else
            on_r <= upper_gate ? on_r + 11'h001 : 11'h000;
    end

    // saturates so a long idle spell cannot wrap into a short one
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            gap_r <= 8'h00;
        else if (upper_gate || lower_gate)
            gap_r <= 8'h00;
        else if (gap_r != 8'hFF)
            gap_r <= gap_r + 8'h01;
    end

    // ----------
    // properties
    // ----------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_no_overlap;
        !(upper_gate && lower_gate);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both gates on together");

    property p_dead;
        $rose(upper_gate) |-> gap_r >= 8'd140;
    endproperty
    a_dead: assert property (p_dead)
        else $error("dead time too short");

    property p_on_time;
        $fell(upper_gate) && !(phase inside {hbbs_pkg::HBBS_OFF,
            hbbs_pkg::HBBS_BOOT}) |-> on_r inside {[11'd401:11'd1001]};
    endproperty
    a_on_time: assert property (p_on_time)
        else $error("half period outside floor and ceiling");

    property p_boot;
        phase == hbbs_pkg::HBBS_BOOT && $past(phase) == hbbs_pkg::HBBS_BOOT
            |-> lower_gate && !upper_gate;
    endproperty
    a_boot: assert property (p_boot)
        else $error("gates wrong while charging bootstrap");

    property p_open;
        phase == hbbs_pkg::HBBS_OPEN && $past(phase) == hbbs_pkg::HBBS_OPEN
            |-> open_load && lower_gate && !upper_gate;
    endproperty
    a_open: assert property (p_open)
        else $error("open load latch gates wrong");

    property p_supply;
        phase == $past(phase) |-> bus_sense_supply_en ==
            (phase inside {hbbs_pkg::HBBS_OFF, hbbs_pkg::HBBS_BOOT});
    endproperty
    a_supply: assert property (p_supply)
        else $error("bus pin supply enable wrong for phase");

    property p_measure;
        phase == $past(phase) |-> bus_sense_measure_en ==
            (phase inside {hbbs_pkg::HBBS_STRIKE, hbbs_pkg::HBBS_RUN,
                           hbbs_pkg::HBBS_RESTART});
    endproperty
    a_measure: assert property (p_measure)
        else $error("bus measure enable wrong for phase");

    property p_start_drop;
        !supply_start_pin [*6] |-> phase == hbbs_pkg::HBBS_OFF;
    endproperty
    a_start_drop: assert property (p_start_drop)
        else $error("no return to off after supply loss");

    property p_osc_only;
        $rose(upper_gate) |-> osc;
    endproperty
    a_osc_only: assert property (p_osc_only)
        else $error("upper gate on outside oscillating phase");
endmodule : hbbs_assertions

// ===== hbbs_load.sv
`timescale 1ns/10ps
module hbbs_load
#(
    parameter int WARM_POINT = 700,
    parameter int RES_POINT  = 900
)
(
    input  wire logic mclk,
    input  wire logic lower_gate,
    input  wire logic force_hard,
    output logic      sense_above_warmup_pin,
    output logic      sense_below_hard_pin
);
    int   on_cnt  = 0;
    int   last_on = 0;
    logic lower_d = 1'b0;

    // lamp current grows as drive frequency falls toward resonance
    always @(posedge mclk)
    begin
        lower_d <= lower_gate;
        on_cnt  <= lower_gate ? on_cnt + 1 : 0;
        if (lower_d && !lower_gate)
            last_on <= on_cnt;
    end

    // below resonance the switches lose zero-voltage switching
    // sense stays above the warmup threshold until current builds up
    assign sense_above_warmup_pin = last_on <= WARM_POINT;
    assign sense_below_hard_pin   = force_hard || last_on > RES_POINT;
endmodule : hbbs_load

// ===== hbbs_sequencer_bench.sv
`timescale 1ns/10ps
module hbbs_sequencer_bench;
    typedef struct packed
    {
        hbbs_pkg::hbbs_supply_type sup;
        hbbs_pkg::hbbs_phase_type  ph;
        logic                      sup_en;
    } hbbs_row_type;

    logic                      mclk;
    logic                      rst_n;
    hbbs_pkg::hbbs_supply_type sup;
    logic                      above_w;
    logic                      below_h;
    logic                      bus_over;
    logic                      tcyc;
    logic                      tgnd;
    logic                      force_hard;
    logic                      upper_gate;
    logic                      lower_gate;
    logic                      sup_en;
    logic                      meas_en;
    logic                      open_load;
    hbbs_pkg::hbbs_phase_type  phase;
    int                        errors;
    int                        check_count;
    int                        t1;
    int                        t2;
    hbbs_row_type              rows [3] = '{
        '{3'h0, hbbs_pkg::HBBS_OFF, 1'b1},
        '{3'h4, hbbs_pkg::HBBS_BOOT, 1'b1},
        '{3'h6, hbbs_pkg::HBBS_WARM, 1'b0}};

    hbbs_sequencer DUT (.mclk(mclk), .rst_n(rst_n),
        .supply_start_pin(sup.start_ok), .supply_run_pin(sup.run_ok),
        .supply_stop_pin(sup.stop_low), .sense_above_warmup_pin(above_w),
        .sense_below_hard_pin(below_h), .bus_over_level_pin(bus_over),
        .timing_cycle_pin(tcyc), .timing_grounded_pin(tgnd),
        .upper_gate(upper_gate), .lower_gate(lower_gate),
        .bus_sense_supply_en(sup_en), .bus_sense_measure_en(meas_en),
        .open_load(open_load), .phase(phase));

    hbbs_load u_load (.mclk(mclk), .lower_gate(lower_gate),
        .force_hard(force_hard), .sense_above_warmup_pin(above_w),
        .sense_below_hard_pin(below_h));

    // ----------
    // tasks
    // ----------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : conclude

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    task automatic pulses(input int n);
        repeat (n)
        begin
            tcyc = 1'b1;
            tick(50);
            tcyc = 1'b0;
            tick(50);
        end
    endtask : pulses

    // skips a pulse already under way so only whole ones are timed
    task automatic on_time(output int t);
        t = 0;
        while (upper_gate === 1'b1 && t < 2000)
        begin
            tick(1);
            t++;
        end
        t = 0;
        while (upper_gate !== 1'b1 && t < 4000)
        begin
            tick(1);
            t++;
        end
        t = 0;
        while (upper_gate === 1'b1 && t < 2000)
        begin
            tick(1);
            t++;
        end
    endtask : on_time

    // ----------
    // stimulus
    // ----------
    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    initial
    begin
        #1000000;
        errors++;
        $display("watchdog expired");
        conclude();
    end

    initial
    begin
        errors = 0;
        check_count = 0;
        sup = 3'h0;
        {bus_over, tcyc, tgnd, force_hard} = 4'h0;
        rst_n = 1'b0;
        tick(6);
        rst_n = 1'b1;
        tick(2);
        check(phase, hbbs_pkg::HBBS_OFF);
        check({sup_en, meas_en, upper_gate, lower_gate, open_load}, 5'h10);
        $display("reset test done");
        for (int i = 0; i < 3; i++)
        begin
            sup = rows[i].sup;
            tick(10);
            check(phase, rows[i].ph);
            check(sup_en, rows[i].sup_en);
        end
        on_time(t1);
        check(t1 <= 410, 1'b1);
        on_time(t2);
        check(t2 > t1, 1'b1);
        $display("supply table done");
        tgnd = 1'b1;
        pulses(20);
        check(phase, hbbs_pkg::HBBS_WARM);
        tick(25000);
        on_time(t1);
        check(t1 > 700, 1'b1);
        on_time(t2);
        check(t2, t1);
        tgnd = 1'b0;
        pulses(15);
        check(phase, hbbs_pkg::HBBS_WARM);
        pulses(1);
        check(phase, hbbs_pkg::HBBS_STRIKE);
        check(meas_en, 1'b1);
        pulses(14);
        check(phase, hbbs_pkg::HBBS_STRIKE);
        pulses(1);
        check(phase, hbbs_pkg::HBBS_RUN);
        $display("warmup and strike test done");
        for (int k = 0; k < 2; k++)
        begin
            tick(3200);
            on_time(t1);
            {bus_over, force_hard} = 2'h1 << k;
            tick(1600);
            on_time(t2);
            {bus_over, force_hard} = 2'h0;
            check(t2 < t1 - 10, 1'b1);
        end
        tick(3200);
        on_time(t1);
        check(t1 > t2, 1'b1);
        $display("frequency raise test done");
        sup = 3'h5;
        tick(10);
        check(phase, hbbs_pkg::HBBS_OFF);
        tick(300);
        check(upper_gate, 1'b0);
        sup = 3'h6;
        tick(10);
        check(phase, hbbs_pkg::HBBS_RESTART);
        on_time(t1);
        check(t1 <= 410, 1'b1);
        pulses(14);
        check(phase, hbbs_pkg::HBBS_RESTART);
        pulses(1);
        check(phase, hbbs_pkg::HBBS_RUN);
        sup = 3'h0;
        tick(10);
        check({phase, upper_gate, lower_gate}, 5'h00);
        $display("restart test done");
        conclude();
    end
endmodule : hbbs_sequencer_bench

bind hbbs_sequencer hbbs_assertions u_chk (.mclk(mclk), .rst_n(rst_n),
    .supply_start_pin(supply_start_pin), .upper_gate(upper_gate),
    .lower_gate(lower_gate), .bus_sense_supply_en(bus_sense_supply_en),
    .bus_sense_measure_en(bus_sense_measure_en), .open_load(open_load),
    .phase(phase));
